/* ssr_pkg.sv */
// shared constants and types for the self refresh link
package ssr_pkg;
    // ***********************************************************
    // command encoding on the link (cs_n, ras_n, cas_n, we_n)
    // ***********************************************************
    localparam logic [3:0] CMD_DES = 4'hf;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_ZQCL = 4'h6;
    localparam logic [3:0] CMD_ACT = 4'h3;

    // ***********************************************************
    // mode register 2 fields
    // ***********************************************************
    localparam int MR2_ASR_BIT = 6;
    localparam int MR2_SRT_BIT = 7;
    localparam logic [2:0] MR2_BANK = 3'h2;

    // ***********************************************************
    // timing, clk is 200 MHz
    // ***********************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TCKE_NS = 5;
    localparam int TCKE_CYC = (TCKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TCKESR_CYC = TCKE_CYC + 1;
    localparam int TXS_NS = 170;
    localparam int TXS_CYC = (TXS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TXSDLL_CYC = 512;
    localparam int TZQOPER_CYC = 256;
    localparam int VREF_WR_CYC = 512;
    localparam int SR_INT_NORMAL_CYC = 1560;
    localparam int SR_INT_EXT_CYC = 780;
    localparam int CNT_W = 12;

    typedef enum logic [3:0] {
        SSR_DV_IDLE = 4'h1,
        SSR_DV_SR = 4'h2,
        SSR_DV_XS = 4'h4,
        SSR_DV_XSDLL = 4'h8
    } ssr_dev_st_t;

    typedef enum logic [6:0] {
        SSR_HS_IDLE = 7'h01,
        SSR_HS_ENTER = 7'h02,
        SSR_HS_NOP = 7'h04,
        SSR_HS_SR = 7'h08,
        SSR_HS_XS = 7'h10,
        SSR_HS_ZQ = 7'h20,
        SSR_HS_XSDLL = 7'h40
    } ssr_host_st_t;
endpackage

/* ssr_link_if.sv */
// link between controller and dram self refresh logic
`timescale 1ns/1ps
interface ssr_link_if;
    logic cke;
    logic reset_n;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [13:0] addr;
    logic odt;

    modport ctrl (output cke, output reset_n, output cmd, output ba, output addr, output odt);
    modport dram (input cke, input reset_n, input cmd, input ba, input addr, input odt);
endinterface

/* ssr_dram.sv */
// dram end: self refresh entry, residency, exit and internal refresh timing
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - refresh with cke low enters self refresh
// - dll off in self refresh, reset on exit
// - entry only with all banks precharged, idle
// - odt low before entry unless termination off
// - cke held low keeps self refresh
// - only cke and reset matter inside
// - first internal refresh within tcke
// - stable clock, exit after tckesr
// - clock change needs tcksre and tcksrx
// - nop or des right after entry
// - only nop or des during txs
// - no re-entry before txs elapses
// - zq long, tzqoper and txsdll before dll commands
// - odt off during txsdll
// - exit delays count from first cke high edge
// - first write 512 clocks after vref valid
// - mr2 bit 7 selects extended range
// - mr2 bit 6 auto rate, bit 7 zero
// - manual refresh doubled above 85 degrees (not done here, left to the refresh scheduler)
// - hot self refresh needs asr or srt
module ssr_dram (
    input wire logic clk,
    input wire logic rst_n,
    ssr_link_if.dram link,
    output logic in_self_refresh,
    output logic dll_on,
    output logic dll_reset,
    output logic int_refresh,
    output logic asr_en,
    output logic srt_en,
    output logic cfg_illegal,
    output logic xs_busy
);
    localparam logic [ssr_pkg::CNT_W-1:0] INT_NORM =
        ssr_pkg::CNT_W'(ssr_pkg::SR_INT_NORMAL_CYC);
    localparam logic [ssr_pkg::CNT_W-1:0] INT_EXT =
        ssr_pkg::CNT_W'(ssr_pkg::SR_INT_EXT_CYC);
    localparam logic [ssr_pkg::CNT_W-1:0] XS_C = ssr_pkg::CNT_W'(ssr_pkg::TXS_CYC);
    localparam logic [ssr_pkg::CNT_W-1:0] XSDLL_C = ssr_pkg::CNT_W'(ssr_pkg::TXSDLL_CYC);

    // ***********************************************************
    // pin synchronisers: cke and reset_n come from off chip
    // ***********************************************************
    logic cke_s1_q, cke_s2_q, rstp_s1_q, rstp_s2_q;
    // command, bank and mode bits ride the same two stages as cke, so a
    // refresh still meets the cke level it was sent with
    logic [3:0] cmd_s1_q, cmd_s2_q;
    logic [2:0] ba_s1_q, ba_s2_q;
    logic [1:0] mrb_s1_q, mrb_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_s1_q <= 1'b1;
            cke_s2_q <= 1'b1;
            rstp_s1_q <= 1'b0;
            rstp_s2_q <= 1'b0;
            cmd_s1_q <= ssr_pkg::CMD_NOP;
            cmd_s2_q <= ssr_pkg::CMD_NOP;
            ba_s1_q <= 3'h0;
            ba_s2_q <= 3'h0;
            mrb_s1_q <= 2'h0;
            mrb_s2_q <= 2'h0;
        end else begin
            cke_s1_q <= link.cke;
            cke_s2_q <= cke_s1_q;
            rstp_s1_q <= link.reset_n;
            rstp_s2_q <= rstp_s1_q;
            cmd_s1_q <= link.cmd;
            cmd_s2_q <= cmd_s1_q;
            ba_s1_q <= link.ba;
            ba_s2_q <= ba_s1_q;
            mrb_s1_q <= {link.addr[ssr_pkg::MR2_SRT_BIT], link.addr[ssr_pkg::MR2_ASR_BIT]};
            mrb_s2_q <= mrb_s1_q;
        end
    end

    // ***********************************************************
    // state
    // ***********************************************************
    ssr_pkg::ssr_dev_st_t st_q, st_d;
    logic [ssr_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic asr_q, asr_d, srt_q, srt_d, dll_q, dll_d, dllr_q, dllr_d, ref_q, ref_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        asr_d = asr_q;
        srt_d = srt_q;
        dll_d = dll_q;
        dllr_d = 1'b0;
        ref_d = 1'b0;
        case (st_q)
            ssr_pkg::SSR_DV_IDLE: begin
                // mode register set outside self refresh only
                if (cke_s2_q && cmd_s2_q == ssr_pkg::CMD_MRS && ba_s2_q == ssr_pkg::MR2_BANK) begin
                    asr_d = mrb_s2_q[0];
                    srt_d = mrb_s2_q[1];
                end
                if (!cke_s2_q && cmd_s2_q == ssr_pkg::CMD_REF) begin
                    st_d = ssr_pkg::SSR_DV_SR;
                    dll_d = 1'b0;
                    ref_d = 1'b1;
                    cnt_d = asr_q || srt_q ? INT_EXT : INT_NORM;
                end
            end
            ssr_pkg::SSR_DV_SR: begin
                // command pins ignored here
                if (cke_s2_q) begin
                    st_d = ssr_pkg::SSR_DV_XS;
                    dll_d = 1'b1;
                    dllr_d = 1'b1;
                    cnt_d = XS_C;
                end else if (cnt_q == '0) begin
                    ref_d = 1'b1;
                    cnt_d = asr_q || srt_q ? INT_EXT : INT_NORM;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ssr_pkg::SSR_DV_XS: begin
                if (cnt_q == '0) begin
                    st_d = ssr_pkg::SSR_DV_XSDLL;
                    cnt_d = XSDLL_C - XS_C;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ssr_pkg::SSR_DV_XSDLL: begin
                if (cnt_q == '0) begin
                    st_d = ssr_pkg::SSR_DV_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: st_d = ssr_pkg::SSR_DV_IDLE;
        endcase
        // reset pin low forces reset state from anywhere
        if (!rstp_s2_q) begin
            st_d = ssr_pkg::SSR_DV_IDLE;
            dll_d = 1'b1;
            asr_d = 1'b0;
            srt_d = 1'b0;
            ref_d = 1'b0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ssr_pkg::SSR_DV_IDLE;
            cnt_q <= '0;
            asr_q <= 1'b0;
            srt_q <= 1'b0;
            dll_q <= 1'b1;
            dllr_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            asr_q <= asr_d;
            srt_q <= srt_d;
            dll_q <= dll_d;
            dllr_q <= dllr_d;
            ref_q <= ref_d;
        end
    end

    assign in_self_refresh = st_q == ssr_pkg::SSR_DV_SR;
    assign xs_busy = st_q == ssr_pkg::SSR_DV_XS;
    assign dll_on = dll_q;
    assign dll_reset = dllr_q;
    assign int_refresh = ref_q;
    assign asr_en = asr_q;
    assign srt_en = srt_q;
    assign cfg_illegal = asr_q & srt_q;
endmodule

/* ssr_ctrl.sv */
// controller end: sequences self refresh entry and exit on the link
`timescale 1ns/1ps
module ssr_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    ssr_link_if.ctrl link,
    input wire logic wr,
    input wire logic rd,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    // ***********************************************************
    // registers: 0 ctrl(bit0 enter, bit1 exit, bit2 clk_alter,
    // bit3 tc_hot, bit4 rtt_on), 1 mr2 value, 2 status
    // ***********************************************************
    localparam int MIN_SR = ssr_pkg::TCKESR_CYC + 8;
    ssr_pkg::ssr_host_st_t st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic [15:0] rd_q, rd_d;
    logic [7:0] mr2_q, mr2_d;
    logic alter_q, alter_d, hot_q, hot_d, rtt_q, rtt_d, req_q, req_d, xreq_q, xreq_d;
    logic cke_q, cke_d, odt_q, odt_d, mrs_q, mrs_d;
    logic [3:0] cmd_q, cmd_d;
    logic sr_ok;

    // hot die needs asr or srt to self refresh
    assign sr_ok = !hot_q || mr2_q[ssr_pkg::MR2_ASR_BIT] || mr2_q[ssr_pkg::MR2_SRT_BIT];

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q == '0 ? cnt_q : cnt_q - 1'b1;
        mr2_d = mr2_q;
        alter_d = alter_q;
        hot_d = hot_q;
        rtt_d = rtt_q;
        req_d = req_q;
        xreq_d = xreq_q;
        mrs_d = 1'b0;
        cke_d = cke_q;
        odt_d = 1'b0; // odt kept low through the sequence
        cmd_d = ssr_pkg::CMD_NOP;
        rd_d = '0;
        if (wr && addr == 2'h0) begin
            req_d = wdata[0];
            xreq_d = wdata[1];
            alter_d = wdata[2];
            hot_d = wdata[3];
            rtt_d = wdata[4];
        end
        if (wr && addr == 2'h1 && st_q == ssr_pkg::SSR_HS_IDLE) begin
            // both bits set is illegal, srt dropped
            mr2_d = wdata[7:0];
            if (wdata[ssr_pkg::MR2_ASR_BIT]) mr2_d[ssr_pkg::MR2_SRT_BIT] = 1'b0;
            mrs_d = 1'b1;
        end
        if (rd) begin
            rd_d = addr == 2'h1 ? {8'h00, mr2_q} :
                   addr == 2'h2 ? {8'h00, sr_ok, 7'(st_q)} : 16'h0000;
        end
        case (st_q)
            ssr_pkg::SSR_HS_IDLE: begin
                if (mrs_q) cmd_d = ssr_pkg::CMD_MRS;
                else if (req_q && sr_ok && cnt_q == '0) begin
                    st_d = ssr_pkg::SSR_HS_ENTER;
                    cke_d = 1'b0;
                    cmd_d = ssr_pkg::CMD_REF;
                end
            end
            ssr_pkg::SSR_HS_ENTER: begin
                st_d = ssr_pkg::SSR_HS_NOP;
                cmd_d = ssr_pkg::CMD_NOP;
                cnt_d = 12'(MIN_SR); // covers tckesr and tcksre
                req_d = 1'b0;
            end
            ssr_pkg::SSR_HS_NOP: begin
                cmd_d = ssr_pkg::CMD_DES;
                if (cnt_q == '0) st_d = ssr_pkg::SSR_HS_SR;
            end
            ssr_pkg::SSR_HS_SR: begin
                cmd_d = ssr_pkg::CMD_DES;
                if (xreq_q && !alter_q) begin // clock stable again
                    st_d = ssr_pkg::SSR_HS_XS;
                    cke_d = 1'b1;
                    xreq_d = 1'b0;
                    cnt_d = 12'(ssr_pkg::TXS_CYC + 2); // sync slack
                end
            end
            ssr_pkg::SSR_HS_XS: begin
                if (cnt_q == '0) begin
                    st_d = ssr_pkg::SSR_HS_ZQ;
                    cmd_d = ssr_pkg::CMD_ZQCL;
                    cnt_d = 12'(ssr_pkg::TXSDLL_CYC + ssr_pkg::VREF_WR_CYC);
                end
            end
            ssr_pkg::SSR_HS_ZQ: begin
                if (cnt_q <= 12'(ssr_pkg::TXSDLL_CYC + ssr_pkg::VREF_WR_CYC
                        - ssr_pkg::TZQOPER_CYC)) st_d = ssr_pkg::SSR_HS_XSDLL;
            end
            ssr_pkg::SSR_HS_XSDLL: begin
                if (cnt_q == '0) st_d = ssr_pkg::SSR_HS_IDLE;
            end
            default: st_d = ssr_pkg::SSR_HS_IDLE;
        endcase
        // refresh period halving when hot is left to the refresh scheduler
        if (rtt_q && st_q == ssr_pkg::SSR_HS_IDLE) odt_d = 1'b1;
        // termination dropped a cycle ahead of the refresh entry
        if (req_d) odt_d = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ssr_pkg::SSR_HS_IDLE;
            cnt_q <= '0;
            rd_q <= '0;
            mr2_q <= '0;
            alter_q <= 1'b0;
            hot_q <= 1'b0;
            rtt_q <= 1'b0;
            req_q <= 1'b0;
            xreq_q <= 1'b0;
            mrs_q <= 1'b0;
            cke_q <= 1'b1;
            odt_q <= 1'b0;
            cmd_q <= ssr_pkg::CMD_NOP;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            mr2_q <= mr2_d;
            alter_q <= alter_d;
            hot_q <= hot_d;
            rtt_q <= rtt_d;
            req_q <= req_d;
            xreq_q <= xreq_d;
            mrs_q <= mrs_d;
            cke_q <= cke_d;
            odt_q <= odt_d;
            cmd_q <= cmd_d;
        end
    end

    assign link.cke = cke_q;
    assign link.reset_n = rst_n;
    assign link.cmd = cmd_q;
    assign link.ba = ssr_pkg::MR2_BANK;
    assign link.addr = {6'h00, mr2_q};
    assign link.odt = odt_q;
    assign rdata = rd_q;
endmodule

/* ssr_assertions.sv */
// concurrent checks on the self refresh link
`timescale 1ns/1ps
module ssr_assertions (
    input logic clk,
    input logic rst_n,
    input logic cke,
    input logic [3:0] cmd,
    input logic odt,
    input logic in_self_refresh,
    input logic dll_reset,
    input logic int_refresh
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cke_q, quiet, xs_win;
    logic [9:0] ex_q, ex_d;
    assign quiet = cmd == ssr_pkg::CMD_NOP || cmd == ssr_pkg::CMD_DES;
    assign xs_win = (cke && !cke_q) || (ex_q != 10'h0 && ex_q < ssr_pkg::TXS_CYC);
    // exit window counts from the first edge that sees cke high
    always_comb begin
        ex_d = (ex_q != 10'h0 && ex_q < ssr_pkg::TXSDLL_CYC - 1) ? ex_q + 10'h1 : 10'h0;
        if (cke && !cke_q) begin
            ex_d = 10'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_q <= 1'b1;
            ex_q <= 10'h0;
        end else begin
            cke_q <= cke;
            ex_q <= ex_d;
        end
    end
    sequence s_entry;
        cmd == ssr_pkg::CMD_REF && !cke;
    endsequence
    sequence s_held;
        in_self_refresh && !cke ##1 !cke;
    endsequence
    a_entry_is_ref: assert property ($fell(cke) |-> cmd == ssr_pkg::CMD_REF)
        else $error("entry without refresh");
    a_nop_after_entry: assert property (s_entry |=> quiet)
        else $error("no nop after entry");
    a_odt_low_entry: assert property (s_entry |-> !odt && !$past(odt))
        else $error("odt high at entry");
    a_dll_reset_exit: assert property ($fell(in_self_refresh) |-> ##[0:3] dll_reset)
        else $error("no dll reset on exit");
    a_stay_while_low: assert property (s_held |-> in_self_refresh)
        else $error("left self refresh early");
    a_first_refresh: assert property ($rose(in_self_refresh) |-> ##[0:1] int_refresh)
        else $error("no refresh at entry");
    a_xs_quiet: assert property (xs_win |-> quiet)
        else $error("command in exit delay");
    a_no_reentry: assert property (xs_win |-> cke)
        else $error("re-entry in exit delay");
    a_odt_off_dll: assert property (ex_q != 10'h0 |-> !odt)
        else $error("odt on in dll lock");
endmodule

/* test_sdram_self_refresh_control.sv */
// self-checking bench: controller and dram joined by the link
`timescale 1ns/1ps
module test_sdram_self_refresh_control;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0, rdata, v = 16'h0;
    logic [7:0] b;
    logic [31:0] seed = 32'h18;
    logic in_self_refresh, dll_on, dll_reset, int_refresh;
    logic asr_en, srt_en, cfg_illegal, xs_busy;
    int error_cnt, compares, ncyc, nref, nzq, ndr, t0, n0, dw;
    ssr_link_if link ();
    ssr_ctrl u_ssr_ctrl (.clk, .rst_n, .link, .wr, .rd, .addr, .wdata, .rdata);
    ssr_dram u_ssr_dram (.clk, .rst_n, .link, .in_self_refresh, .dll_on, .dll_reset,
        .int_refresh, .asr_en, .srt_en, .cfg_illegal, .xs_busy);
    ssr_assertions u_ssr_assertions (.clk, .rst_n, .cke(link.cke), .cmd(link.cmd),
        .odt(link.odt), .in_self_refresh, .dll_reset, .int_refresh);
    initial forever #2.5 clk = ~clk;
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    always @(posedge clk) begin
        ncyc++;
        nref += int'(int_refresh === 1'b1);
        nzq += int'(link.cmd === ssr_pkg::CMD_ZQCL);
        ndr += int'(dll_reset === 1'b1);
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] idle_sts(input logic hot, input logic [7:0] m);
        return {8'h00, !hot || m[6] || m[7], 7'h01};
    endfunction
    // lower bound only: the auto rate may run faster than normal
    function automatic int min_ref(input logic [7:0] m, input int d);
        return d / (m[7] ? ssr_pkg::SR_INT_EXT_CYC : ssr_pkg::SR_INT_NORMAL_CYC);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 2'h2, 16'h0);
        chk(v, idle_sts(1'b0, 8'h00));
        chk({link.cke, link.odt, dll_on, link.cmd}, {3'b101, ssr_pkg::CMD_NOP});
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            b = {m[1], m[0], 6'(xs())};
            bus(1'b1, 2'h1, {8'h00, b});
            for (int i = 0; i < 20 && {asr_en, srt_en} !== {b[6], b[7] && !b[6]}; i++)
                @(posedge clk);
            chk({cfg_illegal, asr_en, srt_en}, {1'b0, b[6], b[7] && !b[6]});
        end
        // hot case with neither rate option: entry must be held off
        bus(1'b1, 2'h1, 16'h0000);
        bus(1'b1, 2'h0, 16'h0009);
        repeat (10) @(posedge clk);
        chk(link.cke, 16'h1);
        bus(1'b0, 2'h2, 16'h0);
        chk(v, idle_sts(1'b1, 8'h00));
        bus(1'b1, 2'h0, 16'h0000);
        $display("test modes done");
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? 8'h00 : ((k == 1) ? 8'h80 : 8'h40);
            bus(1'b1, 2'h1, {8'h00, b});
            n0 = nref;
            bus(1'b1, 2'h0, (k == 0) ? 16'h0011 : 16'h0009);
            for (int i = 0; i < 20 && in_self_refresh !== 1'b1; i++)
                @(posedge clk);
            chk({in_self_refresh, dll_on, link.cke}, 3'b100);
            dw = (k < 2) ? 1700 : 50 + int'(xs() % 32'd200);
            bus(1'b1, 2'h1, {8'h00, 2'b10, 6'(xs())});
            repeat (dw) @(posedge clk);
            chk(in_self_refresh, 16'h1);
            chk(16'(nref - n0 > min_ref(b, dw)), 16'h1);
            t0 = ncyc;
            bus(1'b1, 2'h0, (k == 0) ? 16'h0012 : 16'h000a);
            v = 16'h0;
            for (int i = 0; i < 800 && v[6:0] !== 7'h01; i++)
                bus(1'b0, 2'h2, 16'h0);
            chk(16'(ncyc - t0 > ssr_pkg::TXSDLL_CYC), 16'h1);
            chk(16'(nzq + ndr), 16'(2 * k + 2));
            chk(v, idle_sts(k != 0, b));
            chk({dll_on, in_self_refresh, xs_busy, asr_en, srt_en}, {3'b100, b[6], b[7]});
            $display("test cycle %0d done", k);
        end
        close_out();
    end
endmodule
